//--- logic/scd_pkg.sv
// Package with codes, field positions and phase states for the frame decoder
package scd_pkg;
    // Frame phase states, one-hot
    typedef enum logic [3:0] {
        PH_IDLE = 4'h1,
        PH_ADDR = 4'h2,
        PH_CTRL = 4'h4,
        PH_DATA = 4'h8
    } scd_phase_t;

    // Block-select codes handled here
    localparam logic [4:0] BLK_S6_RSVD = 5'h18;
    localparam logic [4:0] BLK_S6_REG = 5'h19;
    localparam logic [4:0] BLK_S6_TX = 5'h1A;
    localparam logic [4:0] BLK_S6_RX = 5'h1B;
    localparam logic [4:0] BLK_S7_RSVD = 5'h1C;
    localparam logic [4:0] BLK_S7_REG = 5'h1D;
    localparam logic [4:0] BLK_S7_TX = 5'h1E;
    localparam logic [4:0] BLK_S7_RX = 5'h1F;

    // Decoded space codes
    localparam logic [1:0] SPACE_NONE = 2'h0;
    localparam logic [1:0] SPACE_REG = 2'h1;
    localparam logic [1:0] SPACE_TX = 2'h2;
    localparam logic [1:0] SPACE_RX = 2'h3;

    // Control byte field positions
    localparam int CTL_BSB_HI = 7;
    localparam int CTL_BSB_LO = 3;
    localparam int CTL_RW = 2;
    localparam int CTL_OM_HI = 1;
    localparam int CTL_OM_LO = 0;

    // Direction and framing-mode encodings
    localparam logic RW_READ = 1'h0;
    localparam logic RW_WRITE = 1'h1;
    localparam logic [1:0] OM_VARIABLE = 2'h0;

    // Bit counts and reset values
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] SOCK_NONE = 3'h0;
    localparam logic [15:0] ADDR_RST = 16'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [4:0] BLK_RST = 5'h00;
endpackage : scd_pkg

//--- logic/scd_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module scd_sync #(
    parameter int WIDTH = 3
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic [WIDTH-1:0] async_i,
    input wire logic [WIDTH-1:0] rst_val_i,
    output logic [WIDTH-1:0] sync_o
);
    // First stage, read only by the second stage
    logic [WIDTH-1:0] meta;

    // Two stages; reset loads the idle pin level supplied by the parent
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            meta <= rst_val_i;
            sync_o <= rst_val_i;
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end
endmodule : scd_sync

//--- logic/scd_frame_decode.sv
// Serial frame control-phase decoder, slave side of the host link
// Function
// [R1] Codes 11001/11010/11011 give socket 6 spaces
// [R2] Codes 11101/11110/11111 give socket 7 spaces
// [R3] Host never sends reserved codes 11000/11100
// [R4] Direction bit: 0 read, 1 write
// [R5] Two framing modes: variable and fixed length
// [R6] Host drops frame select at address start
// [R7] Mode bits 00 select frame-select-bounded length
// [R8] Frame select rising edge ends data phase
// [R9] Host brackets every frame with frame select
// [R10] Frame select falling edge restarts address phase
`timescale 1ns/100ps
module scd_frame_decode
    import scd_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic sclk_i,
    input wire logic mosi_i,
    input wire logic frame_select_n_i,
    output logic [15:0] addr_o,
    output logic [4:0] block_o,
    output logic [2:0] socket_o,
    output logic [1:0] space_o,
    output logic write_o,
    output logic variable_length_mode_o,
    output logic fixed_length_mode_o,
    output logic reserved_o,
    output logic ctrl_valid_o,
    output logic [7:0] data_o,
    output logic data_valid_o,
    output logic frame_end_o,
    output logic busy_o
);
    // Synchronised pins and their previous values
    logic sclk_s;
    logic mosi_s;
    logic fsn_s;
    logic sclk_prev;
    logic fsn_prev;
    logic [2:0] pins_s;

    // Phase tracking
    scd_phase_t phase;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic addr_lo;            // Second address byte pending

    // Edge and byte events
    logic fs_fall;
    logic fs_rise;
    logic sclk_rise;
    logic byte_done;
    logic ctrl_done;
    logic [7:0] next_byte;

    // Space lookup for one block-select code
    function automatic logic [1:0] space_of(input logic [4:0] code);
        case (code)
            BLK_S6_REG, BLK_S7_REG: space_of = SPACE_REG;
            BLK_S6_TX, BLK_S7_TX: space_of = SPACE_TX;
            BLK_S6_RX, BLK_S7_RX: space_of = SPACE_RX;
            default: space_of = SPACE_NONE;
        endcase
    endfunction : space_of

    // Pins are asynchronous to ref_clk, so all three pass two flops
    scd_sync #(
        .WIDTH(3)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i({sclk_i, mosi_i, frame_select_n_i}),
        .rst_val_i(3'h1),
        .sync_o(pins_s)
    );
    assign sclk_s = pins_s[2];
    assign mosi_s = pins_s[1];
    assign fsn_s = pins_s[0];

    // Previous levels for edge detection
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            sclk_prev <= 1'b0;
            fsn_prev <= 1'b1;
        end else begin
            sclk_prev <= sclk_s;
            fsn_prev <= fsn_s;
        end
    end

    // Edge events; serial clock only counts inside a frame
    assign fs_fall = fsn_prev & ~fsn_s;
    assign fs_rise = ~fsn_prev & fsn_s;
    assign sclk_rise = ~sclk_prev & sclk_s & ~fsn_s & ~fs_fall;
    assign byte_done = sclk_rise && (bit_cnt == BIT_LAST);
    assign next_byte = {shift[6:0], mosi_s};
    assign ctrl_done = byte_done && (phase == PH_CTRL);

    // Phase sequencing; frame select edges take priority over bits
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            phase <= PH_IDLE;
            addr_lo <= 1'b0;
        end else if (fs_fall) begin
            phase <= PH_ADDR; // see [R10]
            addr_lo <= 1'b0;
        end else if (fs_rise) begin
            phase <= PH_IDLE; // see [R8]
        end else if (byte_done) begin
            case (phase)
                PH_ADDR: begin
                    addr_lo <= ~addr_lo;
                    if (addr_lo) begin
                        phase <= PH_CTRL;
                    end
                end
                PH_CTRL: phase <= PH_DATA;
                PH_DATA: phase <= PH_DATA;
                default: phase <= PH_IDLE;
            endcase
        end
    end

    // Bit counter and shifter; a new frame starts from bit zero
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i || fs_fall) begin
            bit_cnt <= BIT_FIRST; // see [R10]
            shift <= BYTE_RST;
        end else if (sclk_rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            shift <= next_byte;
        end
    end

    // Address capture, high byte first
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            addr_o <= ADDR_RST;
        end else if (byte_done && phase == PH_ADDR) begin
            if (addr_lo) begin
                addr_o[7:0] <= next_byte;
            end else begin
                addr_o[15:8] <= next_byte;
            end
        end
    end

    // Control byte decode, held until the next control byte
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            block_o <= BLK_RST;
            socket_o <= SOCK_NONE;
            space_o <= SPACE_NONE;
            write_o <= RW_READ;
            variable_length_mode_o <= 1'b0;
            fixed_length_mode_o <= 1'b0;
            reserved_o <= 1'b0;
        end else if (ctrl_done) begin
            block_o <= next_byte[CTL_BSB_HI:CTL_BSB_LO];
            // Socket number is the top three code bits for mapped spaces
            if (space_of(next_byte[CTL_BSB_HI:CTL_BSB_LO]) != SPACE_NONE) begin
                socket_o <= next_byte[CTL_BSB_HI:CTL_BSB_HI-2]; // see [R1] [R2]
            end else begin
                socket_o <= SOCK_NONE;
            end
            space_o <= space_of(next_byte[CTL_BSB_HI:CTL_BSB_LO]); // see [R1]
            write_o <= next_byte[CTL_RW]; // see [R4]
            // Mode 00 means frame select bounds the data; else fixed
            variable_length_mode_o <=
                next_byte[CTL_OM_HI:CTL_OM_LO] == OM_VARIABLE; // see [R7]
            fixed_length_mode_o <=
                next_byte[CTL_OM_HI:CTL_OM_LO] != OM_VARIABLE; // see [R5]
            // Reserved codes are only flagged; the host must avoid them
            reserved_o <= next_byte[CTL_BSB_HI:CTL_BSB_LO] == BLK_S6_RSVD ||
                next_byte[CTL_BSB_HI:CTL_BSB_LO] == BLK_S7_RSVD; // see [R3]
        end
    end

    // Data bytes, one-cycle event pulses and the busy level
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            data_o <= BYTE_RST;
            data_valid_o <= 1'b0;
            ctrl_valid_o <= 1'b0;
            frame_end_o <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            ctrl_valid_o <= ctrl_done;
            data_valid_o <= byte_done && phase == PH_DATA && !fs_rise;
            if (byte_done && phase == PH_DATA) begin
                data_o <= next_byte;
            end
            // Only a frame that reached the data phase reports an end
            frame_end_o <= fs_rise && phase == PH_DATA; // see [R8]
            busy_o <= ~fsn_s;
        end
    end

    // Frame opening: falling select leads to the address phase
    sequence seq_open;
        fs_fall ##1 (phase == PH_ADDR && bit_cnt == BIT_FIRST);
    endsequence

    // Control byte arrival carrying a given block-select code
    sequence seq_ctrl(logic [4:0] code);
        ctrl_done && next_byte[CTL_BSB_HI:CTL_BSB_LO] == code;
    endsequence

    a_phase_restart: assert property ( // see [R10]
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        fs_fall |-> seq_open)
        else $error("frame start did not restart address phase");

    a_frame_close: assert property ( // see [R8]
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        fs_rise && phase == PH_DATA |=> frame_end_o && phase == PH_IDLE
        ##1 !frame_end_o)
        else $error("frame end not reported as single pulse");

    a_sock6_reg: assert property ( // see [R1]
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        seq_ctrl(BLK_S6_REG) |=> space_o == SPACE_REG && socket_o == 3'h6
        && ctrl_valid_o)
        else $error("socket 6 register code misdecoded");

    a_sock6_bufs: assert property ( // see [R1]
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        seq_ctrl(BLK_S6_TX) or seq_ctrl(BLK_S6_RX) |=> socket_o == 3'h6
        && space_o == (block_o == BLK_S6_TX ? SPACE_TX : SPACE_RX))
        else $error("socket 6 buffer code misdecoded");

    a_sock7_all: assert property ( // see [R2]
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        seq_ctrl(BLK_S7_REG) or seq_ctrl(BLK_S7_TX) or seq_ctrl(BLK_S7_RX)
        |=> socket_o == 3'h7 && space_o == block_o[1:0])
        else $error("socket 7 code misdecoded");

    a_reserved_flag: assert property ( // see [R3]
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        seq_ctrl(BLK_S6_RSVD) or seq_ctrl(BLK_S7_RSVD)
        |=> reserved_o && space_o == SPACE_NONE)
        else $error("reserved code not flagged");

    a_direction_bit: assert property ( // see [R4]
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        ctrl_done |=> write_o == $past(shift[1]) ##1 $stable(write_o))
        else $error("direction bit not held as sent");

    a_mode_select: assert property ( // see [R5] [R7]
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        ctrl_done |=> variable_length_mode_o != fixed_length_mode_o &&
        variable_length_mode_o == ($past(shift[0]) == 1'b0 &&
        $past(mosi_s) == 1'b0))
        else $error("framing mode misdecoded");

    a_data_after_ctrl: assert property ( // see [R8]
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        data_valid_o |-> $past(phase) == PH_DATA && !fsn_prev)
        else $error("data byte outside data phase");
endmodule : scd_frame_decode

//--- test/scd_host_model.sv
// Host-side serial master model that frames transfers for the decoder
`timescale 1ns/100ps
module scd_host_model (
    input wire logic ref_clk_i,
    output logic sclk_o,
    output logic mosi_o,
    output logic frame_select_n_o
);
    localparam int HALF = 4; // Cycles per half bit, above the 3 minimum

    // Idle pins at time zero
    initial begin
        sclk_o = 1'b0;
        mosi_o = 1'b0;
        frame_select_n_o = 1'b1;
    end

    // Select falls ahead of the first address bit
    task automatic begin_frame();
        @(posedge ref_clk_i);
        frame_select_n_o <= 1'b0;
        repeat (HALF) @(posedge ref_clk_i);
    endtask : begin_frame

    // MSB first, data set while clock low
    // Reserved codes go out only when the bench asks
    task automatic shift_bits(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            @(posedge ref_clk_i);
            mosi_o <= b[i];
            repeat (HALF) @(posedge ref_clk_i);
            sclk_o <= 1'b1;
            repeat (HALF) @(posedge ref_clk_i);
            sclk_o <= 1'b0;
        end
    endtask : shift_bits

    // Rise ends the frame; released data line shows stale inverse
    task automatic end_frame();
        repeat (HALF) @(posedge ref_clk_i);
        frame_select_n_o <= 1'b1;
        mosi_o <= ~mosi_o;
        repeat (2 * HALF) @(posedge ref_clk_i);
    endtask : end_frame
endmodule : scd_host_model

//--- test/scd_frame_decode_tb.sv
// Self-checking bench for the frame control-phase decoder
`timescale 1ns/100ps
module scd_frame_decode_tb;
    import scd_pkg::*;
    logic ref_clk_i, sys_rst_i, sclk, mosi, sel_n; // Clock, reset, pins
    logic [15:0] addr;
    logic [4:0] block;
    logic [2:0] socket;
    logic [1:0] space;
    logic wr, var_m, fix_m, rsv, cv, dv, fe, busy;
    logic [7:0] data;
    logic [13:0] cap; // Decoded fields latched at the control pulse
    logic [7:0] data_q[$]; // Reported data bytes
    int num_errors = 0;
    int samples_checked = 0;
    int ctrl_seen, end_seen; // Pulse counts per run_frame call

    scd_frame_decode scd_frame_decode_inst (.ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i), .sclk_i(sclk), .mosi_i(mosi),
        .frame_select_n_i(sel_n), .addr_o(addr), .block_o(block),
        .socket_o(socket), .space_o(space), .write_o(wr),
        .variable_length_mode_o(var_m), .fixed_length_mode_o(fix_m),
        .reserved_o(rsv), .ctrl_valid_o(cv), .data_o(data),
        .data_valid_o(dv), .frame_end_o(fe), .busy_o(busy));
    scd_host_model scd_host_model_inst (.ref_clk_i(ref_clk_i),
        .sclk_o(sclk), .mosi_o(mosi), .frame_select_n_o(sel_n));

    // 50 ns clock
    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end

    // Pulses are one cycle wide, so catch them every edge
    always @(posedge ref_clk_i) begin
        if (cv === 1'b1) begin
            cap <= {block, socket, space, wr, var_m, fix_m, rsv};
            ctrl_seen++;
        end
        if (dv === 1'b1) data_q.push_back(data);
        if (fe === 1'b1) end_seen++;
    end

    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s exp %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic stop_test();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    // Whole frame with n data bytes counting up from base
    task automatic run_frame(logic [15:0] a, logic [7:0] c, int n,
                             logic [7:0] base);
        ctrl_seen = 0;
        end_seen = 0;
        data_q.delete();
        scd_host_model_inst.begin_frame();
        scd_host_model_inst.shift_bits(a[15:8], 8);
        scd_host_model_inst.shift_bits(a[7:0], 8);
        scd_host_model_inst.shift_bits(c, 8);
        for (int i = 0; i < n; i++) begin
            scd_host_model_inst.shift_bits(base + 8'(i), 8);
        end
        scd_host_model_inst.end_frame();
        #1;
    endtask : run_frame

    // Every code of both sockets, both directions, all mode values
    task automatic decode_codes();
        logic [4:0] code;
        logic [1:0] om, sp;
        logic [2:0] sk;
        logic [13:0] ex; // Expected fields, in the order of cap
        for (int c = 0; c < 8; c++) begin
            code = {2'h3, 3'(c)};
            om = 2'(c >> 1);
            sp = (code[1:0] == 2'h1) ? SPACE_REG :
                 (code[1:0] == 2'h2) ? SPACE_TX :
                 (code[1:0] == 2'h3) ? SPACE_RX : SPACE_NONE;
            sk = (sp == SPACE_NONE) ? 3'h0 : (code[2] ? 3'h7 : 3'h6);
            ex = {code, sk, sp, 1'(c), om == 2'h0, om != 2'h0,
                  code[1:0] == 2'h0};
            run_frame(16'h0100, {code, 1'(c), om}, 1, 8'h5A);
            check("ctrl_count", 16'(ctrl_seen), 16'h0001);
            check("target", 16'(cap[13:4]), 16'(ex[13:4]));
            check("reserved", 16'(cap[0]), 16'(ex[0]));
            check("mode", 16'(cap[3:1]), 16'(ex[3:1]));
        end
    endtask : decode_codes

    // Several bytes bounded only by select
    task automatic data_frame();
        run_frame(16'hA55A, {BLK_S6_TX, RW_WRITE, OM_VARIABLE}, 3, 8'hC3);
        check("addr", addr, 16'hA55A);
        check("bytes", 16'(data_q.size()), 16'h0003);
        for (int i = 0; i < 3; i++) begin
            check("byte", 16'(data_q[i]), 16'(8'hC3 + 8'(i)));
        end
        check("frame_end", 16'(end_seen), 16'h0001);
        check("busy", 16'(busy), 16'h0000);
    endtask : data_frame

    // Cut-off frame, then a fresh one must decode from its address
    task automatic abort_restart();
        scd_host_model_inst.begin_frame();
        // Select fall has passed the synchroniser by now
        check("busy", 16'(busy), 16'h0001);
        scd_host_model_inst.shift_bits(8'hFF, 8);
        scd_host_model_inst.shift_bits(8'hF0, 4);
        scd_host_model_inst.end_frame();
        run_frame(16'h1234, {BLK_S7_RX, RW_READ, OM_VARIABLE}, 0, 8'h00);
        check("addr", addr, 16'h1234);
        check("block", 16'(block), 16'h001F);
        check("write", 16'(wr), 16'h0000);
        check("frame_end", 16'(end_seen), 16'h0001);
    endtask : abort_restart

    // Reset ten cycles, then the scenarios
    initial begin
        sys_rst_i = 1'b1;
        repeat (10) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        decode_codes();
        data_frame();
        abort_restart();
        stop_test();
    end

    // Eleven frames take about 3300 cycles; cut a hang well beyond that
    initial begin
        repeat (40000) @(posedge ref_clk_i);
        num_errors++;
        stop_test();
    end
endmodule : scd_frame_decode_tb
